// ---- es_defines.svh ----
`ifndef ES_DEFINES_SVH
`define ES_DEFINES_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define ES_CLK_MHZ 200
`define ES_STBY_NS 200
`define ES_NVW_MS 10
`define ES_POR_MS 100
`define ES_STBY_CYC (`ES_STBY_NS * `ES_CLK_MHZ / 1000)
`define ES_NVW_CYC (`ES_NVW_MS * 1000 * `ES_CLK_MHZ)
`define ES_POR_CYC (`ES_POR_MS * 1000 * `ES_CLK_MHZ)

// ----------------------------------------
// Widths
// ----------------------------------------
`define ES_TMR_W 25
`define ES_LING_W 6
`define ES_WADDR_W 14
`define ES_BYTE_W 8
`define ES_CNT_W 4

// ----------------------------------------
// Address byte layout and framing
// ----------------------------------------
`define ES_RW_BIT 0
`define ES_SEL_LO_BIT 1
`define ES_SEL_HI_BIT 2
`define ES_ZERO_BIT 3
`define ES_TYPE_LSB 4
`define ES_TYPE_MSB 7
`define ES_LAST_BIT 4'h7
`define ES_ACK_BIT 4'h8
`define ES_STOP_BIT 4'h1
`define ES_WADDR_BYTES 2'h2
`define ES_DATA_SEEN 2'h3
`define ES_SEQ_DONE 2'h3

`endif

// ---- es_pkg.sv ----
`include "es_defines.svh"

package es_pkg;

    // ----------------------------------------
    // Front end states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ES_STANDBY,
        ES_ADDR,
        ES_XFER,
        ES_READ,
        ES_IGNORE,
        ES_LINGER
    } es_state_t;

    typedef struct packed {
        es_state_t st;
        logic sda_m1;
        logic sda_s;
        logic sda_p;
        logic scl_m1;
        logic scl_s;
        logic scl_p;
        logic wp_m1;
        logic wp_s;
        logic tg_m1;
        logic tg_s;
        logic tg_p;
        logic [`ES_CNT_W-1:0] bitc;
        logic [1:0] bytes;
        logic rd;
        logic ack_pend;
        logic sda_o;
        logic sda_oe_n;
        logic [`ES_LING_W-1:0] linger;
        logic [`ES_TMR_W-1:0] nvw;
        logic [`ES_TMR_W-1:0] por;
        logic sup_rst;
        logic active;
        logic busy;
        logic write_enable_latch;
        logic [1:0] seq;
        logic grant;
        logic refuse;
        logic nv_start;
        logic [`ES_WADDR_W-1:0] waddr;
        logic [`ES_BYTE_W-1:0] wdat;
        logic wdat_v;
        logic lrst_n;
        logic fresh;
    } es_core_t;

    typedef struct packed {
        logic [`ES_BYTE_W-1:0] sh;
        logic [`ES_BYTE_W-1:0] data;
        logic [`ES_CNT_W-1:0] cnt;
        logic tgl;
    } es_link_t;

endpackage : es_pkg

// ---- es_link_if.sv ----
`timescale 1ns/10ps
`include "es_defines.svh"

interface es_link_if;
    logic scl;
    logic sda;
    logic rst_n;
    logic fresh;
    logic tgl;
    logic [`ES_BYTE_W-1:0] data;

    modport link (input scl, input sda, input rst_n, input fresh, output tgl, output data);
    modport core (output scl, output sda, output rst_n, output fresh, input tgl, input data);
endinterface : es_link_if

// ---- es_link.sv ----
`timescale 1ns/10ps
`include "es_defines.svh"

module es_link
    import es_pkg::*;
(
    es_link_if.link lnk
);

    es_link_t q;
    es_link_t d;
    logic [`ES_CNT_W-1:0] cnt_eff;

    // ----------------------------------------
    // Bit shifter on the bus clock
    // ----------------------------------------
    // Fresh is held by the core from start to the first rise, so it is stable at every edge
    always_comb begin
        d = q;
        cnt_eff = lnk.fresh ? '0 : q.cnt;
        if (cnt_eff == `ES_ACK_BIT) begin
            d.cnt = '0;
        end else begin
            d.sh = {q.sh[`ES_BYTE_W-2:0], lnk.sda};
            d.cnt = cnt_eff + 4'h1;
            if (cnt_eff == `ES_LAST_BIT) begin
                d.data = {q.sh[`ES_BYTE_W-2:0], lnk.sda};
                d.tgl = ~q.tgl;
            end
        end
    end

    always_ff @(posedge lnk.scl or negedge lnk.rst_n) begin
        if (!lnk.rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lnk.tgl = q.tgl;
    assign lnk.data = q.data;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_byte_toggle: assert property (@(posedge lnk.scl) disable iff (!lnk.rst_n) // [R4]
        (!lnk.fresh && q.cnt == `ES_LAST_BIT) |=> (q.tgl != $past(q.tgl)))
        else $error("byte not handed over after eighth bit");

endmodule : es_link

// ---- es_front.sv ----
`timescale 1ns/10ps
`include "es_defines.svh"

// Function
// R1: Master sends type code then zero bit
// R2: Two select bits compared with own setting
// R3: Last address bit: one read, zero write
// R4: Compare whole byte, acknowledge only on match
// R5: Word address from master or counter; the code only loads it from the master's two address bytes
// R6: Power-up in standby, data line input
// R7: Write-enable latch cleared at power-up
// R8: Supervisor reset held for power-up timeout
// R9: Writes need write-enable latch set first
// R10: Nonvolatile write needs correct clocks, bits
// R11: Lock changes need three-step sequence
// R12: Protect pin plus enable refuses control writes
// R13: Supervisor reset ignores bus, aborts transfer
// R14: Region locks block protected array writes
// R15: Start wakes; mismatch sleeps nine clocks later
// R16: Plain stop sleeps 200 ns later
// R17: Write stop stays active through write time
// R18: Write time at most 10 ms
// R19: No acknowledge while write cycle runs
// R20: Mismatch releases line, ignores until start
module es_front
    import es_pkg::*;
#(
    parameter int POR_CYCLES = `ES_POR_CYC,
    parameter int NVW_CYCLES = `ES_NVW_CYC,
    // Arbitrary value
    parameter logic [3:0] TYPE_CODE = 4'h6
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic WP,
    input wire logic DEVICE_SELECT_HIGH,
    input wire logic DEVICE_SELECT_LOW,
    input wire logic PROTECT_PIN_ENABLE,
    input wire logic REGION_LOCKED,
    input wire logic WEL_SET,
    input wire logic WEL_CLR,
    input wire logic SEQ_STEP,
    input wire logic CTRL_WR_REQ,
    input wire logic CTRL_WR_LOCKCHG,
    input wire logic SUP_RESET_REQ,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    output logic SUP_RESET,
    output logic ACTIVE,
    output logic READ_SEL,
    output logic WRITE_ENABLE_LATCH,
    output logic NV_WRITE_START,
    output logic NV_BUSY,
    output logic CTRL_WR_GRANT,
    output logic CTRL_WR_REFUSE,
    output logic [`ES_WADDR_W-1:0] WORD_ADDR,
    output logic [`ES_BYTE_W-1:0] WR_DATA,
    output logic WR_DATA_VALID
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (POR_CYCLES < 2 || POR_CYCLES >= (1 << `ES_TMR_W)) begin : g_bad_por
        $error("POR_CYCLES out of range");
    end
    if (NVW_CYCLES < 2 || NVW_CYCLES >= (1 << `ES_TMR_W)) begin : g_bad_nvw
        $error("NVW_CYCLES out of range");
    end

    localparam logic [`ES_TMR_W-1:0] POR_INIT = POR_CYCLES[`ES_TMR_W-1:0];
    localparam logic [`ES_TMR_W-1:0] NVW_INIT = NVW_CYCLES[`ES_TMR_W-1:0]; // [R18]
    localparam logic [`ES_LING_W-1:0] STBY_INIT = `ES_LING_W'(`ES_STBY_CYC);

    es_core_t q;
    es_core_t n;
    es_link_if lnk ();

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_ev;
    logic addr_match;
    logic stop_valid;
    logic ctrl_ok;

    // ----------------------------------------
    // Link side
    // ----------------------------------------
    assign lnk.scl = SCL;
    assign lnk.sda = SDA_IN;
    assign lnk.rst_n = q.lrst_n;
    assign lnk.fresh = q.fresh;

    es_link u_link (
        .lnk(lnk)
    );

    // ----------------------------------------
    // Bus events from synchronised pins
    // ----------------------------------------
    assign scl_rise = q.scl_s & ~q.scl_p;
    assign scl_fall = ~q.scl_s & q.scl_p;
    assign start_ev = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop_ev = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    // Data word is stable for nine bus clocks after its toggle, far beyond sync delay
    assign byte_ev = q.tg_s ^ q.tg_p;

    always_comb begin
        addr_match = 1'b0;
        if (lnk.data[`ES_TYPE_MSB:`ES_TYPE_LSB] == TYPE_CODE // [R1]
            && !lnk.data[`ES_ZERO_BIT]
            && lnk.data[`ES_SEL_HI_BIT] == DEVICE_SELECT_HIGH // [R2]
            && lnk.data[`ES_SEL_LO_BIT] == DEVICE_SELECT_LOW) begin
            addr_match = 1'b1;
        end
    end

    // Stop only counts after a full data byte and its acknowledge clock
    // The stop's own clock rise is already counted as bit one
    assign stop_valid = (q.st == ES_XFER) && (q.bytes == `ES_DATA_SEEN) // [R10]
        && (q.bitc == `ES_STOP_BIT);

    assign ctrl_ok = q.write_enable_latch // [R9]
        && !(q.wp_s && PROTECT_PIN_ENABLE) // [R12]
        && (!CTRL_WR_LOCKCHG || q.seq == `ES_SEQ_DONE) // [R11]
        && !q.sup_rst;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = q;
        n.grant = 1'b0;
        n.refuse = 1'b0;
        n.nv_start = 1'b0;
        n.wdat_v = 1'b0;
        n.lrst_n = 1'b1;
        n.sda_m1 = SDA_IN;
        n.sda_s = q.sda_m1;
        n.sda_p = q.sda_s;
        n.scl_m1 = SCL;
        n.scl_s = q.scl_m1;
        n.scl_p = q.scl_s;
        n.wp_m1 = WP;
        n.wp_s = q.wp_m1;
        n.tg_m1 = lnk.tgl;
        n.tg_s = q.tg_m1;
        n.tg_p = q.tg_s;

        if (q.por != '0) begin
            n.por = q.por - 25'h1;
        end
        if (q.nvw != '0) begin
            n.nvw = q.nvw - 25'h1;
        end

        if (WEL_SET) begin
            n.write_enable_latch = 1'b1;
        end else if (WEL_CLR) begin
            n.write_enable_latch = 1'b0;
        end

        if (SEQ_STEP && q.seq != `ES_SEQ_DONE) begin
            n.seq = q.seq + 2'h1;
        end
        if (CTRL_WR_REQ) begin
            n.grant = ctrl_ok;
            n.refuse = !ctrl_ok;
            n.seq = '0;
        end

        if (scl_rise) begin
            n.fresh = 1'b0;
            n.bitc = (q.bitc == `ES_ACK_BIT) ? '0 : q.bitc + 4'h1;
        end

        if (q.ack_pend && scl_fall) begin
            n.sda_oe_n = 1'b0;
            n.ack_pend = 1'b0;
        end else if (!q.sda_oe_n && scl_fall) begin
            n.sda_oe_n = 1'b1;
        end

        if (q.sup_rst) begin
            // Any frame in flight is dropped and the line let go
            n.st = ES_STANDBY; // [R13]
            n.ack_pend = 1'b0;
            n.sda_oe_n = 1'b1;
            n.fresh = 1'b0;
        end else if (start_ev) begin
            n.st = ES_ADDR; // [R15]
            n.bitc = '0;
            n.bytes = '0;
            n.ack_pend = 1'b0;
            n.sda_oe_n = 1'b1;
            n.fresh = 1'b1;
        end else if (stop_ev && q.st != ES_STANDBY) begin
            n.ack_pend = 1'b0;
            n.sda_oe_n = 1'b1;
            if (stop_valid && q.write_enable_latch && !REGION_LOCKED) begin // [R14]
                n.nv_start = 1'b1;
                n.nvw = NVW_INIT; // [R17]
                n.st = ES_STANDBY;
            end else begin
                n.st = ES_LINGER; // [R16]
                n.linger = STBY_INIT;
            end
        end else begin
            unique case (q.st)
                ES_STANDBY: begin
                end
                ES_ADDR: begin
                    if (byte_ev) begin
                        if (addr_match && !q.busy) begin // [R4] [R19]
                            n.ack_pend = 1'b1;
                            n.rd = lnk.data[`ES_RW_BIT]; // [R3]
                            n.st = lnk.data[`ES_RW_BIT] ? ES_READ : ES_XFER;
                        end else begin
                            n.st = ES_IGNORE; // [R20]
                        end
                    end
                end
                ES_XFER: begin
                    if (byte_ev) begin
                        if (q.bytes < `ES_WADDR_BYTES) begin
                            n.waddr = {q.waddr[`ES_WADDR_W-`ES_BYTE_W-1:0], lnk.data}; // [R5]
                            n.bytes = q.bytes + 2'h1;
                            n.ack_pend = 1'b1;
                        end else begin
                            n.wdat = lnk.data;
                            n.wdat_v = q.write_enable_latch && !REGION_LOCKED; // [R9] [R14]
                            n.bytes = `ES_DATA_SEEN;
                            n.ack_pend = !REGION_LOCKED; // [R14]
                        end
                    end
                end
                ES_READ: begin
                end
                ES_IGNORE: begin
                    if (scl_rise && q.bitc == `ES_ACK_BIT) begin
                        n.st = ES_STANDBY; // [R15]
                    end
                end
                ES_LINGER: begin
                    n.linger = q.linger - 6'h1;
                    if (q.linger <= 6'h1) begin
                        n.st = ES_STANDBY; // [R16]
                    end
                end
            endcase
        end

        n.sup_rst = (n.por != '0) || SUP_RESET_REQ; // [R8]
        n.busy = n.nvw != '0;
        n.active = (n.st != ES_STANDBY) || n.busy; // [R17]
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Standby, line released, latch clear, link held in reset
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            q <= '{default: '0, st: ES_STANDBY, sda_oe_n: 1'b1, por: POR_INIT, // [R6] [R7]
                sup_rst: 1'b1}; // [R8]
        end else begin
            q <= n;
        end
    end

    assign SDA_OUT = q.sda_o;
    assign SDA_OE_N = q.sda_oe_n;
    assign SUP_RESET = q.sup_rst;
    assign ACTIVE = q.active;
    assign READ_SEL = q.rd;
    assign WRITE_ENABLE_LATCH = q.write_enable_latch;
    assign NV_WRITE_START = q.nv_start;
    assign NV_BUSY = q.busy;
    assign CTRL_WR_GRANT = q.grant;
    assign CTRL_WR_REFUSE = q.refuse;
    assign WORD_ADDR = q.waddr;
    assign WR_DATA = q.wdat;
    assign WR_DATA_VALID = q.wdat_v;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    logic addr_take;
    assign addr_take = q.st == ES_ADDR && byte_ev && !q.sup_rst && !start_ev && !stop_ev;

    chk_ack_on_match: assert property ( // [R4]
        addr_take && addr_match && !q.busy |=> q.ack_pend ##[1:400] !q.sda_oe_n)
        else $error("matched address not acknowledged");

    chk_no_ack_busy: assert property ( // [R19]
        addr_take && q.busy |=> !q.ack_pend && q.st == ES_IGNORE)
        else $error("address acknowledged during write cycle");

    chk_mismatch_free: assert property ( // [R20]
        addr_take && !addr_match |=> q.st == ES_IGNORE && !q.ack_pend)
        else $error("mismatch did not release the bus");

    chk_rw_select: assert property ( // [R3]
        addr_take && addr_match && !q.busy |=> q.rd == $past(lnk.data[`ES_RW_BIT])
            && (q.st == ES_READ) == q.rd)
        else $error("read or write not taken from last bit");

    chk_wel_gate: assert property ( // [R9]
        q.nv_start || q.wdat_v |-> $past(q.write_enable_latch))
        else $error("write took effect with latch clear");

    chk_valid_stop: assert property ( // [R10]
        q.nv_start |-> $past(q.bytes) == `ES_DATA_SEEN && $past(q.bitc) == `ES_STOP_BIT
            && !$past(REGION_LOCKED))
        else $error("write launched without a complete byte");

    chk_write_hold: assert property ( // [R17]
        q.nv_start |-> q.nvw == NVW_INIT ##1 q.active && q.busy)
        else $error("write cycle not held active");

    chk_linger_end: assert property ( // [R16]
        q.st == ES_LINGER && q.linger == 6'h1 && !q.sup_rst && !start_ev && !stop_ev
            |=> q.st == ES_STANDBY)
        else $error("standby not reached after stop delay");

    chk_ignore_nine: assert property ( // [R15]
        q.st == ES_IGNORE && scl_rise && q.bitc == `ES_ACK_BIT && !q.sup_rst
            && !start_ev && !stop_ev |=> q.st == ES_STANDBY)
        else $error("mismatch did not return to standby");

    chk_reset_abort: assert property ( // [R13]
        q.sup_rst |=> q.st == ES_STANDBY && q.sda_oe_n && !q.ack_pend)
        else $error("bus not dropped under supervisor reset");

    chk_por_hold: assert property ( // [R8]
        q.por > 25'h1 |=> q.sup_rst)
        else $error("supervisor reset released early");

    chk_ctrl_pin: assert property ( // [R12]
        CTRL_WR_REQ && q.wp_s && PROTECT_PIN_ENABLE |=> q.refuse && !q.grant)
        else $error("control write passed protect pin");

    chk_ctrl_seq: assert property ( // [R11]
        CTRL_WR_REQ && CTRL_WR_LOCKCHG && q.seq != `ES_SEQ_DONE |=> !q.grant)
        else $error("lock change without full sequence");

    cov_ack: cover property (q.ack_pend ##[1:400] !q.sda_oe_n);
    cov_nv_start: cover property (q.nv_start);
    cov_ignore: cover property (q.st == ES_IGNORE ##[1:1000] q.st == ES_STANDBY);
    cov_grant: cover property (q.grant && CTRL_WR_LOCKCHG);

endmodule : es_front

// ---- es_master.sv ----
`timescale 1ns/10ps

module es_master #(
    parameter int Q_NS = 16
) (
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    // ----------------------------------------
    // Two-wire bus master model
    // ----------------------------------------
    // Clock stands high between frames; data is only ever released, never driven high
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic start_cond();
        #(Q_NS) sda_rel = 1'b1;
        #(Q_NS) scl = 1'b1;
        #(2*Q_NS) sda_rel = 1'b0;
        #(2*Q_NS) scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #(Q_NS) sda_rel = 1'b0;
        #(Q_NS) scl = 1'b1;
        #(2*Q_NS) sda_rel = 1'b1;
        #(2*Q_NS);
    endtask : stop_cond

    // Data changes mid-low, sampled mid-high
    task automatic bit_cyc(input logic b, output logic s);
        #(Q_NS) sda_rel = b;
        #(Q_NS) scl = 1'b1;
        #(Q_NS) s = sda_line;
        #(Q_NS) scl = 1'b0;
    endtask : bit_cyc

    // Short counts model an aborted byte with no ack clock
    task automatic send_byte(input logic [7:0] v, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 0; i < n; i++) begin
            bit_cyc(v[7-i], s);
        end
        if (n == 8) begin
            bit_cyc(1'b1, s);
            ack = !s;
        end
    endtask : send_byte
endmodule : es_master

// ---- es_front_bench.sv ----
`timescale 1ns/10ps
`include "es_defines.svh"

module es_front_bench;
    // ----------------------------------------
    // Setup
    // ----------------------------------------
    localparam int POR = 20;
    localparam int NVW = 400;
    localparam int LIMIT = 30000;
    // Arbitrary type code, design built to match
    localparam logic [3:0] TC = 4'h6;
    localparam logic [7:0] AW = {TC, 4'h4};
    localparam logic [7:0] AR = {TC, 4'h5};
    localparam logic [7:0] BAD [4] = '{{TC ^ 4'h1, 4'h4}, {TC, 4'hC}, {TC, 4'h0}, {TC, 4'h6}};
    // Control cases: wel, wp, pin enable, lock change, steps[1:0], expected grant
    localparam logic [6:0] CT [8] = '{7'h41, 7'h70, 7'h61, 7'h51, 7'h4C, 7'h4F, 7'h00, 7'h7E};
    logic clk, nrst, wp, dsh, dsl, pen, rlk, wset, wclr, step, creq, cchg, sreq;
    logic sda_out, sda_oe_n, sup, act, rsel, write_enable_latch, nvs, nvb, grant, refuse, wdv;
    logic [13:0] waddr;
    logic [7:0] wdat;
    logic scl, sda_rel, ack;
    logic [3:0] acks;
    logic [13:0] nv_cnt, wdv_cnt;
    int err_total, check_count, cyc;
    wire sda_line = sda_rel & (sda_oe_n | sda_out);

    es_front #(.POR_CYCLES(POR), .NVW_CYCLES(NVW), .TYPE_CODE(TC)) u_es_front (
        .CORE_CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda_line), .WP(wp),
        .DEVICE_SELECT_HIGH(dsh), .DEVICE_SELECT_LOW(dsl), .PROTECT_PIN_ENABLE(pen),
        .REGION_LOCKED(rlk), .WEL_SET(wset), .WEL_CLR(wclr), .SEQ_STEP(step),
        .CTRL_WR_REQ(creq), .CTRL_WR_LOCKCHG(cchg), .SUP_RESET_REQ(sreq),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SUP_RESET(sup), .ACTIVE(act),
        .READ_SEL(rsel), .WRITE_ENABLE_LATCH(write_enable_latch), .NV_WRITE_START(nvs), .NV_BUSY(nvb),
        .CTRL_WR_GRANT(grant), .CTRL_WR_REFUSE(refuse), .WORD_ADDR(waddr),
        .WR_DATA(wdat), .WR_DATA_VALID(wdv));

    es_master u_es_master (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nvs === 1'b1) nv_cnt <= nv_cnt + 14'h1;
        if (wdv === 1'b1) wdv_cnt <= wdv_cnt + 14'h1;
        if (cyc == LIMIT) begin
            err_total++;
            final_report();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string nm, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_vec

    // Top two word address bits sent as ones: they must be dropped
    task automatic wr(input logic [7:0] a, input logic [13:0] wa, input logic [7:0] d,
                      input int nb);
        u_es_master.start_cond();
        u_es_master.send_byte(a, 8, acks[3]);
        u_es_master.send_byte({2'h3, wa[13:8]}, 8, acks[2]);
        u_es_master.send_byte(wa[7:0], 8, acks[1]);
        u_es_master.send_byte(d, nb, acks[0]);
    endtask : wr

    task automatic addr_only(input logic [7:0] a);
        u_es_master.start_cond();
        u_es_master.send_byte(a, 8, ack);
    endtask : addr_only

    task automatic ctrl(input logic [6:0] c);
        wset = c[6];
        wclr = !c[6];
        wp = c[5];
        pen = c[4];
        tick(1);
        wset = 1'b0;
        wclr = 1'b0;
        tick(4);
        step = (c[2:1] != 2'h0);
        repeat (c[2:1]) tick(1);
        step = 1'b0;
        creq = 1'b1;
        cchg = c[3];
        tick(1);
        creq = 1'b0;
        chk_bit("grant", c[0], grant);
        chk_bit("refuse", !c[0], refuse);
        tick(1);
        chk_bit("grant_len", 1'b0, grant);
    endtask : ctrl

    task automatic final_report();
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {nrst, wp, pen, rlk, wset, wclr, step, creq, cchg, sreq, dsl} = '0;
        dsh = 1'b1;
        {nv_cnt, wdv_cnt} = '0;
        cyc = 0;
        err_total = 0;
        check_count = 0;
        tick(2);
        chk_bit("oe_n_rst", 1'b1, sda_oe_n);
        chk_bit("active_rst", 1'b0, act);
        chk_bit("wel_rst", 1'b0, write_enable_latch);
        chk_bit("sup_rst", 1'b1, sup);
        tick(3);
        nrst = 1'b1;
        tick(10);
        chk_bit("sup_hold", 1'b1, sup);
        tick(15);
        chk_bit("sup_end", 1'b0, sup);
        // Plain address, then a stop with no write
        addr_only(AW);
        chk_bit("ack_w", 1'b1, ack);
        chk_bit("active_w", 1'b1, act);
        chk_bit("rsel_w", 1'b0, rsel);
        u_es_master.stop_cond();
        tick(28);
        chk_bit("active_hold", 1'b1, act);
        tick(20);
        chk_bit("active_stop", 1'b0, act);
        addr_only(AR);
        chk_bit("ack_r", 1'b1, ack);
        chk_bit("rsel_r", 1'b1, rsel);
        u_es_master.stop_cond();
        tick(50);
        // Wrong type, zero bit or select bits; line stays released
        for (int i = 0; i < 4; i++) begin
            addr_only(BAD[i]);
            chk_bit("ack_bad", 1'b0, ack);
            tick(4);
            chk_bit("active_bad", 1'b0, act);
            u_es_master.send_byte(AW, 8, ack);
            chk_bit("ack_ignored", 1'b0, ack);
            u_es_master.stop_cond();
        end
        // Latch clear: nothing launched
        wr(AW, 14'h2A5C, 8'hC3, 8);
        chk_vec("word_addr", 14'h2A5C, waddr);
        u_es_master.stop_cond();
        tick(50);
        chk_vec("nv_none", 14'h0, nv_cnt);
        chk_vec("wdv_none", 14'h0, wdv_cnt);
        wset = 1'b1;
        tick(1);
        wset = 1'b0;
        tick(1);
        chk_bit("wel_set", 1'b1, write_enable_latch);
        rlk = 1'b1;
        wr(AW, 14'h0101, 8'h11, 8);
        chk_bit("ack_locked", 1'b0, acks[0]);
        u_es_master.stop_cond();
        rlk = 1'b0;
        // Stop before data, then stop mid data byte
        for (int i = 0; i < 2; i++) begin
            wr(AW, 14'h0202, 8'hF0, i * 4);
            u_es_master.stop_cond();
            tick(50);
        end
        chk_vec("nv_short", 14'h0, nv_cnt);
        chk_vec("wdv_lock", 14'h0, wdv_cnt);
        wr(AW, 14'h1234, 8'h5A, 8);
        chk_vec("acks", 14'hF, {10'h0, acks});
        chk_vec("word_addr2", 14'h1234, waddr);
        chk_vec("wr_data", 14'h5A, {6'h0, wdat});
        u_es_master.stop_cond();
        tick(3);
        chk_vec("nv_one", 14'h1, nv_cnt);
        chk_vec("wdv_one", 14'h1, wdv_cnt);
        chk_bit("nv_busy", 1'b1, nvb);
        addr_only(AW);
        chk_bit("ack_poll", 1'b0, ack);
        u_es_master.stop_cond();
        tick(60);
        chk_bit("active_nv", 1'b1, act);
        for (int i = 0; i < NVW && nvb === 1'b1; i++) tick(1);
        chk_bit("nv_done", 1'b0, nvb);
        tick(3);
        chk_bit("active_nv_end", 1'b0, act);
        addr_only(AW);
        chk_bit("ack_poll_end", 1'b1, ack);
        u_es_master.stop_cond();
        tick(50);
        for (int i = 0; i < 8; i++) ctrl(CT[i]);
        wp = 1'b0;
        wset = 1'b1;
        tick(1);
        wset = 1'b0;
        // Supervisor reset in mid transfer
        addr_only(AW);
        u_es_master.send_byte(8'h01, 8, ack);
        tick(1);
        sreq = 1'b1;
        u_es_master.send_byte(8'h23, 8, ack);
        chk_bit("ack_sup", 1'b0, ack);
        chk_bit("sup_req", 1'b1, sup);
        u_es_master.send_byte(8'h77, 8, ack);
        u_es_master.stop_cond();
        tick(1);
        sreq = 1'b0;
        tick(50);
        chk_vec("nv_sup", 14'h1, nv_cnt);
        chk_bit("sup_off", 1'b0, sup);
        addr_only(AW);
        chk_bit("ack_after", 1'b1, ack);
        u_es_master.stop_cond();
        tick(50);
        final_report();
    end
endmodule : es_front_bench
